// *** rtl/sfcp_client_port.sv ***
`timescale 1ns/1ps
// Contract
// - end-of-frame flag per receive segment
// - receive error valid only at qualified end
// - error on FCS, length, bad code
// - 3-bit receive empty count per segment
// - receive enable qualifies all receive outputs
// - short frame: start and end together
// - first byte on lowest byte lane
// - non-final receive transfers fill full width
// - ready high when accepting; client stops
// - transmit transfer only with valid high
// - disabled transmit segment is ignored
// - poison sampled only at enabled finish
// - poison replaces final word with error code
// - poisoned packet skips FCS checking
// - transmit empty sampled at valid finish
// - two 64-bit segments, numbered 0, 1
// - packets begin/end in any segment
// - all transmit signals on rising edge
// - zero empty means all lanes valid
// - underflow flagged when supply falls short
module sfcp_client_port (
    input wire logic clk,
    input wire logic rst_n,
    // receive, from the MAC core
    input wire logic mac_rx_valid,
    input wire sfcp_pkg::sfcp_bus_s mac_rx_bus,
    input wire logic [1:0] mac_rx_code_bad,

    // receive, to the client
    output logic rx_valid,
    output sfcp_pkg::sfcp_bus_s rx_bus,

    // transmit, from the client
    input wire logic tx_valid,
    input wire sfcp_pkg::sfcp_bus_s tx_bus,
    output logic tx_ready,
    output logic tx_underflow,

    // transmit, to the MAC core
    output logic mac_tx_valid,
    output sfcp_pkg::sfcp_bus_s mac_tx_bus,
    input wire logic mac_tx_ready
);

    // ****************************************
    // receive length and error tracking
    // ****************************************
    logic [sfcp_pkg::LEN_BITS-1:0] rx_len;
    logic rx_code_seen;
    logic [sfcp_pkg::LEN_BITS-1:0] next_rx_len;
    logic next_rx_code_seen;
    sfcp_pkg::sfcp_bus_s next_rx_bus;

    always_comb begin
        logic [sfcp_pkg::LEN_BITS:0] acc;
        logic seen;

        // running count picks up where the last beat left off
        acc = {1'b0, rx_len};
        seen = rx_code_seen;

        // idle segments leave the stage as all zero
        next_rx_bus = '0;
        // segment 0 accounted before segment 1
        for (int s = 0; s < sfcp_pkg::SEG_COUNT; s++) begin
            if (mac_rx_valid && mac_rx_bus[s].en) begin
                // a frame may open in either segment
                if (mac_rx_bus[s].sop) begin
                    acc = '0;
                    seen = 1'b0;
                end

                // a bad block anywhere in the frame taints its end
                seen = seen | mac_rx_code_bad[s];

                // full segments add 8, the last one 8 less its empty lanes
                if (mac_rx_bus[s].eop) begin
                    acc = acc + (sfcp_pkg::LEN_BITS+1)'(sfcp_pkg::SEG_BYTES)
                        - (sfcp_pkg::LEN_BITS+1)'(mac_rx_bus[s].empty);
                end else begin
                    acc = acc + (sfcp_pkg::LEN_BITS+1)'(sfcp_pkg::SEG_BYTES);
                end
                // saturate so a runaway frame still reads as too long
                if (acc[sfcp_pkg::LEN_BITS]) begin
                    acc = {1'b0, sfcp_pkg::LEN_SATURATE};
                end


                // lanes passed in order, byte 0 on bits 7:0
                next_rx_bus[s].en = 1'b1;
                next_rx_bus[s].data = mac_rx_bus[s].data;
                // sop and eop pass together for short frames
                next_rx_bus[s].sop = mac_rx_bus[s].sop;
                next_rx_bus[s].eop = mac_rx_bus[s].eop;

                if (mac_rx_bus[s].eop) begin
                    // empty count carried only at frame end
                    next_rx_bus[s].empty = mac_rx_bus[s].empty;
                    // fcs, length range, or bad block code
                    next_rx_bus[s].err = mac_rx_bus[s].err | seen
                        | (acc[sfcp_pkg::LEN_BITS-1:0] < sfcp_pkg::FRAME_MIN_LEN)
                        | (acc[sfcp_pkg::LEN_BITS-1:0] > sfcp_pkg::FRAME_MAX_LEN);
                end else begin
                    next_rx_bus[s].empty = sfcp_pkg::EMPTY_NONE;
                    // error only at the qualified end
                    next_rx_bus[s].err = 1'b0;
                end
            end
        end

        // carried into the next beat of the same frame
        next_rx_len = acc[sfcp_pkg::LEN_BITS-1:0];
        next_rx_code_seen = seen;
    end

    // frame state, held between beats
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_len <= '0;
            rx_code_seen <= 1'b0;
        end else begin
            rx_len <= next_rx_len;
            rx_code_seen <= next_rx_code_seen;
        end
    end

    // ****************************************
    // receive output stage
    // ****************************************
    // no stall path: the client must take every qualified beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid <= 1'b0;
            rx_bus <= '0;
        end else begin
            rx_valid <= mac_rx_valid;

            // zeroed when idle so stale lanes never look live
            rx_bus <= mac_rx_valid ? next_rx_bus : '0;
        end
    end

    // ****************************************
    // transmit segment sanitising
    // ****************************************
    sfcp_pkg::sfcp_bus_s tx_clean;

    // two 64-bit segments
    // each segment is cleaned on its own; no cross-segment logic here
    genvar g;
    generate
        for (g = 0; g < sfcp_pkg::SEG_COUNT; g++) begin : g_tx_seg
            always_comb begin
                tx_clean[g] = '0;

                // poison and empty are dropped unless the segment ends here
                // a disabled segment carries nothing
                if (tx_bus[g].en) begin
                    tx_clean[g].en = 1'b1;
                    tx_clean[g].sop = tx_bus[g].sop;
                    tx_clean[g].eop = tx_bus[g].eop;
                    tx_clean[g].data = tx_bus[g].data;
                    if (tx_bus[g].eop) begin
                        // empty count taken only at finish
                        tx_clean[g].empty = tx_bus[g].empty;
                        // poison taken only at enabled finish
                        if (tx_bus[g].err) begin
                            // final word becomes the error code
                            tx_clean[g].data = {sfcp_pkg::SEG_BYTES{sfcp_pkg::ERROR_CODE_BYTE}};
                            // tells the MAC to skip FCS for this packet
                            tx_clean[g].err = 1'b1;
                        end
                    end else begin
                        tx_clean[g].empty = sfcp_pkg::EMPTY_NONE;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // transmit two-entry buffer
    // ****************************************
    // two entries let ready be a flop without losing the beat in flight
    sfcp_pkg::sfcp_bus_s buf_mem [sfcp_pkg::BUF_DEPTH];
    logic buf_wr_ptr;
    logic buf_rd_ptr;
    logic [1:0] buf_count;
    logic buf_push;
    logic buf_pop;

    assign buf_push = tx_valid && tx_ready;
    assign buf_pop = (buf_count != 2'h0) && (!mac_tx_valid || mac_tx_ready);

    // all transmit state on the rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_wr_ptr <= 1'b0;
            buf_rd_ptr <= 1'b0;
            buf_count <= 2'h0;
            // ready stays low in reset so nothing lands early
            tx_ready <= 1'b0;
        end else begin
            // one-bit pointers wrap over the two entries
            if (buf_push) begin
                buf_wr_ptr <= ~buf_wr_ptr;
            end

            if (buf_pop) begin
                buf_rd_ptr <= ~buf_rd_ptr;
            end

            case ({buf_push, buf_pop})
                // fill: ready drops as the second entry lands
                2'b10: begin
                    buf_count <= buf_count + 2'h1;
                    tx_ready <= (buf_count + 2'h1) != sfcp_pkg::BUF_FULL;
                end
                // drain: a free slot always reopens ready
                2'b01: begin
                    buf_count <= buf_count - 2'h1;
                    tx_ready <= 1'b1;
                end
                // idle, or push with pop: level unchanged
                default: begin
                    tx_ready <= buf_count != sfcp_pkg::BUF_FULL;
                end
            endcase
        end
    end

    // storage needs no reset: entries are read only once counted
    always_ff @(posedge clk) begin
        if (buf_push) begin
            buf_mem[buf_wr_ptr] <= tx_clean;
        end
    end

    // stall by the MAC holds this stage, then fills the buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_tx_valid <= 1'b0;
            mac_tx_bus <= '0;
        end else if (!mac_tx_valid || mac_tx_ready) begin
            // valid follows pop so a drained buffer drops valid
            mac_tx_valid <= buf_pop;
            if (buf_pop) begin
                mac_tx_bus <= buf_mem[buf_rd_ptr];
            end
        end
    end

    // ****************************************
    // transmit underflow watch
    // ****************************************
    logic tx_in_pkt;
    logic next_tx_in_pkt;

    always_comb begin
        next_tx_in_pkt = tx_in_pkt;

        // later segment wins: a finish after a begin closes the packet
        if (buf_push) begin
            for (int s = 0; s < sfcp_pkg::SEG_COUNT; s++) begin
                if (tx_clean[s].sop) begin
                    next_tx_in_pkt = 1'b1;
                end
                if (tx_clean[s].eop) begin
                    next_tx_in_pkt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_in_pkt <= 1'b0;
            tx_underflow <= 1'b0;
        end else begin
            tx_in_pkt <= next_tx_in_pkt;

            // one pulse per idle cycle; the MAC sees a gap in the frame
            // cause is judged on last cycle's levels, hence one cycle late
            // ready offered mid-packet but no beat came
            tx_underflow <= tx_in_pkt && tx_ready && !tx_valid;
        end
    end

endmodule

// *** rtl/sfcp_pkg.sv ***
package sfcp_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int SEG_COUNT = 2;
    localparam int SEG_BYTES = 8;
    localparam int SEG_BITS = 64;
    localparam int EMPTY_BITS = 3;
    localparam int LEN_BITS = 14;

    // ****************************************
    // frame limits and codes
    // ****************************************
    localparam logic [LEN_BITS-1:0] FRAME_MIN_LEN = 14'h0040;
    localparam logic [LEN_BITS-1:0] FRAME_MAX_LEN = 14'h2400;
    localparam logic [LEN_BITS-1:0] LEN_SATURATE = 14'h3FFF;
    localparam logic [7:0] ERROR_CODE_BYTE = 8'hFE;
    localparam logic [EMPTY_BITS-1:0] EMPTY_NONE = 3'h0;
    localparam logic [SEG_BITS-1:0] SEG_ZERO = 64'h0;

    // ****************************************
    // buffer geometry
    // ****************************************
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;

    // one segment: first byte in bits 7:0
    typedef struct packed {
        logic en;
        logic sop;
        logic eop;
        logic err;
        logic [EMPTY_BITS-1:0] empty;
        logic [SEG_BITS-1:0] data;
    } sfcp_seg_s;

    // segment 1 is index 1; segment 0 carries the earlier bytes
    typedef sfcp_seg_s [SEG_COUNT-1:0] sfcp_bus_s;

endpackage

// *** tb/segmented_frame_client_port_test.sv ***
`timescale 1ns/1ps
module segmented_frame_client_port_test;
    // ****************
    // harness
    // ****************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mac_rx_valid = 1'b0;
    sfcp_pkg::sfcp_bus_s mac_rx_bus = '0;
    logic [1:0] mac_rx_code_bad = 2'h0;
    logic tx_valid = 1'b0;
    sfcp_pkg::sfcp_bus_s tx_bus = '0;
    logic stall = 1'b0;
    logic rx_valid, tx_ready, tx_underflow, mac_tx_valid, mac_tx_ready;
    sfcp_pkg::sfcp_bus_s rx_bus, mac_tx_bus;
    int taken, fail_count = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    sfcp_client_port i_dut (.clk(clk), .rst_n(rst_n), .mac_rx_valid(mac_rx_valid),
        .mac_rx_bus(mac_rx_bus), .mac_rx_code_bad(mac_rx_code_bad), .rx_valid(rx_valid),
        .rx_bus(rx_bus), .tx_valid(tx_valid), .tx_bus(tx_bus), .tx_ready(tx_ready),
        .tx_underflow(tx_underflow), .mac_tx_valid(mac_tx_valid),
        .mac_tx_bus(mac_tx_bus), .mac_tx_ready(mac_tx_ready));
    sfcp_core_sink i_sink (.clk(clk), .stall(stall), .mac_tx_valid(mac_tx_valid),
        .mac_tx_ready(mac_tx_ready), .taken(taken));
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    task automatic check(input logic [141:0] seen, input logic [141:0] want, input string m);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    function automatic sfcp_pkg::sfcp_seg_s seg(input logic [3:0] f, input logic [63:0] d);
        return {f, 3'h0, d};
    endfunction
    task automatic rx_beat(input sfcp_pkg::sfcp_bus_s b, input logic [1:0] bad,
        input sfcp_pkg::sfcp_bus_s w);
        mac_rx_valid = 1'b1;
        mac_rx_bus = b;
        mac_rx_code_bad = bad;
        tick;
        check(rx_valid, 1'b1, "rx valid");
        check(rx_bus, w, "rx segments");
    endtask
    // holds the beat until ready is seen high at an edge
    task automatic tx_send(input sfcp_pkg::sfcp_bus_s b);
        logic acc;
        tx_valid = 1'b1;
        tx_bus = b;
        acc = 1'b0;
        while (!acc) begin
            @(posedge clk);
            acc = tx_ready;
            #2;
        end
    endtask
    task automatic tx_take(input sfcp_pkg::sfcp_bus_s w);
        int n;
        n = 0;
        while (!(mac_tx_valid && mac_tx_ready) && n < 20) begin
            tick;
            n++;
        end
        check(mac_tx_bus, w, "tx out");
        tick;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_rx_frames;
        sfcp_pkg::sfcp_bus_s b, w;
        b = '0;
        b[0] = seg(4'hE, 64'h8877665544332211);
        w = b;
        w[0].err = 1'b1;
        rx_beat(b, 2'h0, w);
        // good, fcs bad, code bad, one byte short
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 5; k++) begin
                b = '0;
                if (k < 4) b[1] = seg({1'b1, k == 0, 2'h0}, 64'h0F0E0D0C0B0A0908 + 64'(k));
                if (k > 0) b[0] = seg({2'h2, k == 4, c == 1 && k == 4}, 64'h0706 + 64'(k));
                if (c == 3 && k == 4) b[0].empty = 3'h1;
                w = b;
                w[0].err = (k == 4) && (c != 0);
                rx_beat(b, (c == 2 && k == 2) ? 2'h1 : 2'h0, w);
            end
        end
        mac_rx_valid = 1'b0;
        $display("rx frames done");
    endtask
    task automatic t_tx_poison;
        sfcp_pkg::sfcp_bus_s b, w, w2;
        stall = 1'b1;
        b[0] = seg(4'hC, 64'h1111111111111111);
        b[1] = seg(4'hB, 64'h2222222222222222);
        w = b;
        w[1].data = {8{sfcp_pkg::ERROR_CODE_BYTE}};
        tx_send(b);
        b[0] = seg(4'hE, 64'h3333333333333333);
        b[1] = seg(4'h7, 64'h4444444444444444);
        w2 = b;
        w2[1] = '0;
        tx_send(b);
        tx_valid = 1'b0;
        repeat (4) tick;
        check(mac_tx_bus, w, "poisoned beat");
        stall = 1'b0;
        tx_take(w);
        tx_take(w2);
        $display("tx poison done");
    endtask
    task automatic t_tx_fill;
        sfcp_pkg::sfcp_bus_s b;
        int n;
        stall = 1'b1;
        n = 0;
        repeat (8) begin
            b[0] = seg(4'hC, 64'(n));
            b[1] = seg(4'hA, 64'(n + 16));
            tx_valid = 1'b1;
            tx_bus = b;
            @(posedge clk);
            if (tx_ready) n++;
            #2;
        end
        tx_valid = 1'b0;
        check(tx_ready, 1'b0, "buffer refuses");
        stall = 1'b0;
        for (int k = 0; k < n; k++) begin
            b[0] = seg(4'hC, 64'(k));
            b[1] = seg(4'hA, 64'(k + 16));
            tx_take(b);
        end
        $display("tx fill done, %0d held", n);
    endtask
    task automatic t_underflow;
        sfcp_pkg::sfcp_bus_s b;
        int t0;
        t0 = taken;
        b = '0;
        b[0] = seg(4'hC, 64'h44);
        tx_send(b);
        tx_valid = 1'b0;
        tick;
        check(tx_underflow, 1'b1, "underflow");
        b[0] = seg(4'hA, 64'h55);
        b[0].empty = 3'h3;
        tx_send(b);
        tx_valid = 1'b0;
        repeat (6) tick;
        check(tx_underflow, 1'b0, "no underflow");
        check(32'(taken - t0), 32'h2, "beat count");
        $display("underflow done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (2) tick;
        t_rx_frames;
        t_tx_poison;
        t_tx_fill;
        t_underflow;
        tally_and_finish;
    end
endmodule

// *** tb/sfcp_client_port_sva.sv ***
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module sfcp_client_port_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mac_rx_valid,
    input wire sfcp_pkg::sfcp_bus_s mac_rx_bus,
    input wire logic rx_valid,
    input wire sfcp_pkg::sfcp_bus_s rx_bus,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_underflow,
    input wire logic mac_tx_valid,
    input wire sfcp_pkg::sfcp_bus_s mac_tx_bus,
    input wire logic mac_tx_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_rx_one_late: assert property (mac_rx_valid |=> rx_valid)
        else $error("rx beat lost");
    chk_rx_quiet: assert property (!rx_valid |-> rx_bus == '0)
        else $error("rx bus not idle");
    chk_rx_lanes: assert property (mac_rx_valid && mac_rx_bus[1].en
        |=> rx_bus[1].data == $past(mac_rx_bus[1].data))
        else $error("rx lanes moved");
    chk_rx_short: assert property (mac_rx_valid && mac_rx_bus[0][70:68] == 3'h7
        |=> rx_bus[0].sop && rx_bus[0].eop && rx_bus[0].err)
        else $error("short frame marks wrong");
    chk_rx_empty_mid: assert property (rx_valid && !rx_bus[0].eop
        |-> rx_bus[0].empty == 3'h0)
        else $error("empty count outside end");
    chk_rx_err_qual: assert property (rx_bus[1].err
        |-> rx_valid && rx_bus[1].en && rx_bus[1].eop)
        else $error("error flag unqualified");
    chk_tx_hold: assert property (mac_tx_valid && !mac_tx_ready
        |=> mac_tx_valid && $stable(mac_tx_bus))
        else $error("tx beat changed under stall");
    chk_tx_poison: assert property (mac_tx_valid && mac_tx_bus[1].err
        |-> mac_tx_bus[1].data == {8{sfcp_pkg::ERROR_CODE_BYTE}})
        else $error("poisoned word not replaced");
    chk_unf_cause: assert property (tx_underflow
        |-> $past(tx_ready) && !$past(tx_valid))
        else $error("underflow without idle supply");
    cover property (tx_underflow);
    cover property (mac_tx_valid && mac_tx_bus[1].err);
    cover property (rx_valid && rx_bus[0].eop && rx_bus[0].err);
endmodule
bind sfcp_client_port sfcp_client_port_sva i_chk (.clk(clk), .rst_n(rst_n),
    .mac_rx_valid(mac_rx_valid), .mac_rx_bus(mac_rx_bus), .rx_valid(rx_valid),
    .rx_bus(rx_bus), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_underflow(tx_underflow), .mac_tx_valid(mac_tx_valid),
    .mac_tx_bus(mac_tx_bus), .mac_tx_ready(mac_tx_ready));

// *** tb/sfcp_core_sink.sv ***
`timescale 1ns/1ps
// ****************
// core-side transmit sink
// ****************
module sfcp_core_sink (
    input wire logic clk,
    input wire logic stall,
    input wire logic mac_tx_valid,
    output logic mac_tx_ready,
    output int taken
);
    initial taken = 0;
    initial mac_tx_ready = 1'b0;
    always @(posedge clk) begin
        mac_tx_ready <= !stall;
        if (mac_tx_valid && mac_tx_ready) begin
            taken <= taken + 1;
        end
    end
endmodule
